// ### src/acl_entry.v
// Match and action logic of one access control entry
`timescale 1ns/100ps
`include "acl_regs.vh"
module acl_entry #(
	parameter NP = 8,
	parameter PW = 3,
	parameter CW = 32
) (
	input  wire          ref_clk,
	input  wire          srst,
	input  wire          in_valid,
	output wire          in_ready,
	input  wire [7:0]    in_data,
	input  wire          in_sof,
	input  wire          in_eof,
	input  wire [PW-1:0] in_port,
	input  wire          cfg_entry_en,
	input  wire [NP-1:0] cfg_port_mask,
	input  wire [1:0]    cfg_frame_type,
	input  wire [15:0]   cfg_etype,
	input  wire          cfg_permit,
	input  wire          cfg_src_filter,
	input  wire [47:0]   cfg_src_value,
	input  wire          cfg_mirror_en,
	input  wire [PW-1:0] cfg_mirror_port,
	input  wire          cfg_log_en,
	input  wire          cfg_shutdown_en,
	input  wire          cfg_redirect_en,
	input  wire [PW-1:0] cfg_redirect_port,
	input  wire [4:0]    cfg_rate_sel,
	input  wire          cnt_clr,
	input  wire [NP-1:0] shutdown_clr,
	output wire          dec_valid,
	output wire [PW-1:0] dec_port,
	output wire          dec_mirror,
	output wire [PW-1:0] dec_mirror_port,
	output wire          dec_mirror_limit,
	output wire          dec_redirect,
	output wire [PW-1:0] dec_redirect_port,
	output wire          dec_rate_limit_en,
	output wire [4:0]    dec_rate_units,
	output wire [NP-1:0] port_disable,
	output wire [CW-1:0] hit_count,
	output wire          log_valid,
	input  wire          log_ready,
	output wire [7:0]    log_data,
	output wire          log_last,
	output wire          log_drop
);
	reg  [11:0]   pos_reg;
	reg  [11:0]   etpos_reg;
	reg  [1:0]    tags_reg;
	reg  [7:0]    et_hi_reg;
	reg  [15:0]   etype_reg;
	reg           hdr_done_reg;
	reg  [47:0]   smac_reg;
	reg  [PW-1:0] port_reg;
	reg           log_frame_reg;
	reg           mirror_en_reg;
	reg           dec_valid_reg;
	reg  [PW-1:0] dec_port_reg;
	reg           dec_mirror_reg;
	reg  [PW-1:0] dec_mirror_port_reg;
	reg           dec_redirect_reg;
	reg  [PW-1:0] dec_redirect_port_reg;
	reg           dec_rate_en_reg;
	reg  [4:0]    dec_rate_units_reg;
	reg  [NP-1:0] port_disable_reg;
	wire [NP-1:0] port_disable_next;
	reg  [CW-1:0] hit_count_reg;
	reg  [CW-1:0] hit_count_next;

	wire          take;
	wire [11:0]   idx;
	wire [11:0]   etpos;
	wire [1:0]    tags;
	wire [PW-1:0] port_now;
	wire [15:0]   etype_word;
	wire          is_tpid;
	wire          type_ok;
	wire          src_ok;
	wire          match;
	wire [11:0]   frame_len;
	wire          short_frame;
	wire          hit;
	wire          log_frame;
	wire          strip_ready;
	wire          strip_valid;
	wire [7:0]    strip_data;
	wire          strip_last;
	wire          strip_drop;
	wire          fifo_ready;
	wire [9:0]    fifo_out;
	wire [NP-1:0] port_sel;
	wire          shut_set;
	wire          hdr_done;
	genvar        gp;

	// Rate selection is decoded for both the enable and the units field
	function rate_ok;
		input [4:0] sel;
		begin
			rate_ok = (sel >= `ACL_RATE_MIN) && (sel <= `ACL_RATE_MAX);
		end
	endfunction

	// One-hot ingress port, shared by the port mask check and the shutdown set
	function [NP-1:0] port_onehot;
		input [PW-1:0] port;
		begin
			port_onehot = {{(NP-1){1'b0}}, 1'b1} << port;
		end
	endfunction

	// Inputs sample a frame from its first byte, so header state restarts on in_sof
	assign take      = in_valid & in_ready;
	assign idx       = in_sof ? 12'h000 : pos_reg;
	assign etpos     = in_sof ? `ACL_ETYPE_POS : etpos_reg;
	assign tags      = in_sof ? 2'h0 : tags_reg;
	assign port_now  = in_sof ? in_port : port_reg;
	assign log_frame = in_sof ? cfg_log_en : log_frame_reg;

	// Logging stalls the source only for frames that feed the log path
	assign in_ready  = ~log_frame | strip_ready;

	// Type word pairs the held high byte with the byte now on the bus
	assign etype_word = {et_hi_reg, in_data};
	assign is_tpid    = (etype_word == `ACL_TPID_C) | (etype_word == `ACL_TPID_S);

	always @(posedge ref_clk) begin
		if (srst) begin
			pos_reg       <= 12'h000;
			etpos_reg     <= `ACL_ETYPE_POS;
			tags_reg      <= 2'h0;
			et_hi_reg     <= 8'h00;
			etype_reg     <= 16'h0000;
			hdr_done_reg  <= 1'b0;
			smac_reg      <= 48'h0000_0000_0000;
			port_reg      <= {PW{1'b0}};
			log_frame_reg <= 1'b0;
		end else if (take) begin
			pos_reg       <= (idx == `ACL_POS_MAX) ? idx : idx + 12'h001;
			etpos_reg     <= etpos;
			tags_reg      <= tags;
			port_reg      <= port_now;
			log_frame_reg <= log_frame;
			if (in_sof) begin
				hdr_done_reg <= 1'b0;
			end
			if (idx >= `ACL_SMAC_FIRST && idx <= `ACL_SMAC_LAST) begin
				smac_reg <= {smac_reg[39:0], in_data};
			end
			if (idx == etpos) begin
				et_hi_reg <= in_data;
			end
			// Stacked tags move the type field on and do not count toward length
			if (idx == etpos + 12'h001 && !hdr_done_reg) begin
				if (is_tpid && tags != `ACL_MAX_TAGS) begin
					etpos_reg <= etpos + `ACL_TAG_BYTES;
					tags_reg  <= tags + 2'h1;
				end else begin
					etype_reg    <= etype_word;
					hdr_done_reg <= 1'b1;
				end
			end
		end
	end

	// Type class and source address check
	assign type_ok = (cfg_frame_type == `ACL_FT_ANY) |
			((cfg_frame_type == `ACL_FT_ETYPE) & (etype_reg == cfg_etype)) |
			((cfg_frame_type == `ACL_FT_ARP) & (etype_reg == `ACL_ETYPE_ARP));
	assign src_ok  = (cfg_frame_type == `ACL_FT_ANY) |
			(cfg_src_filter == `ACL_SRC_ANY) |
			(smac_reg == cfg_src_value);
	// A first byte that is also the last byte never carries a complete header
	assign hdr_done = hdr_done_reg & ~in_sof;
	assign match   = cfg_entry_en & hdr_done & (|(cfg_port_mask & port_sel)) &
			type_ok & src_ok;

	// Length counts the check sequence but no tags
	assign frame_len   = idx + 12'h001 - {8'h00, tags, 2'b00};
	assign short_frame = (frame_len < `ACL_MAX_LEN);
	assign hit         = take & in_eof & match;

	// Registered enable reads disabled straight out of reset
	always @(posedge ref_clk) begin
		if (srst) begin
			mirror_en_reg <= 1'b0;
		end else begin
			mirror_en_reg <= cfg_mirror_en;
		end
	end

	// One decision carries the mirror, redirect and rate actions of the frame
	always @(posedge ref_clk) begin
		if (srst) begin
			dec_valid_reg         <= 1'b0;
			dec_port_reg          <= {PW{1'b0}};
			dec_mirror_reg        <= 1'b0;
			dec_mirror_port_reg   <= {PW{1'b0}};
			dec_redirect_reg      <= 1'b0;
			dec_redirect_port_reg <= {PW{1'b0}};
			dec_rate_en_reg       <= 1'b0;
			dec_rate_units_reg    <= 5'h00;
		end else begin
			dec_valid_reg <= hit;
			if (hit) begin
				dec_port_reg          <= port_now;
				dec_mirror_reg        <= mirror_en_reg;
				dec_mirror_port_reg   <= cfg_mirror_port;
				dec_redirect_reg      <= cfg_redirect_en & ~cfg_permit;
				dec_redirect_port_reg <= cfg_redirect_port;
				dec_rate_en_reg       <= rate_ok(cfg_rate_sel);
				dec_rate_units_reg    <= rate_ok(cfg_rate_sel) ? cfg_rate_sel : 5'h00;
			end
		end
	end

	// The limiter never touches the mirror copy; it still governs the forwarded frame
	assign dec_valid         = dec_valid_reg;
	assign dec_port          = dec_port_reg;
	assign dec_mirror        = dec_mirror_reg;
	assign dec_mirror_port   = dec_mirror_port_reg;
	assign dec_mirror_limit  = 1'b0;
	assign dec_redirect      = dec_redirect_reg;
	assign dec_redirect_port = dec_redirect_port_reg;
	assign dec_rate_limit_en = dec_rate_en_reg;
	assign dec_rate_units    = dec_rate_units_reg;

	// Shut ports stay down until cleared; a new shutdown wins over a clear
	assign port_sel = port_onehot(port_now);
	assign shut_set = hit & cfg_shutdown_en & short_frame;
	generate
		for (gp = 0; gp < NP; gp = gp + 1) begin : g_shut
			assign port_disable_next[gp] = (shut_set & port_sel[gp]) |
					(port_disable_reg[gp] & ~shutdown_clr[gp]);
		end
	endgenerate

	// A hit in the clearing cycle is kept as the first count
	always @* begin
		hit_count_next = cnt_clr ? {CW{1'b0}} : hit_count_reg;
		if (hit) begin
			hit_count_next = hit_count_next + {{(CW-1){1'b0}}, 1'b1};
		end
	end

	always @(posedge ref_clk) begin
		if (srst) begin
			port_disable_reg <= {NP{1'b0}};
		end else begin
			port_disable_reg <= port_disable_next;
		end
	end

	// The counter wraps silently; software must read it often enough to see turnover
	always @(posedge ref_clk) begin
		if (srst) begin
			hit_count_reg <= {CW{1'b0}};
		end else begin
			hit_count_reg <= hit_count_next;
		end
	end

	assign port_disable = port_disable_reg;
	assign hit_count    = hit_count_reg;

	// Match is known only at the last byte, so the record ends with a keep or drop mark
	acl_fcs_strip u_strip (
		.ref_clk   (ref_clk),
		.srst      (srst),
		.in_valid  (in_valid & log_frame),
		.in_ready  (strip_ready),
		.in_data   (in_data),
		.in_last   (in_eof),
		.in_drop   (~(match & short_frame)),
		.out_valid (strip_valid),
		.out_ready (fifo_ready),
		.out_data  (strip_data),
		.out_last  (strip_last),
		.out_drop  (strip_drop)
	);

	// Limited log storage: a slow log reader back-pressures ingress
	acl_fifo #(
		.WIDTH (10),
		.DEPTH (`ACL_FIFO_DEPTH),
		.AW    (4)
	) u_log_fifo (
		.ref_clk  (ref_clk),
		.srst     (srst),
		.wr_valid (strip_valid),
		.wr_ready (fifo_ready),
		.wr_data  ({strip_drop & strip_last, strip_last, strip_data}),
		.rd_valid (log_valid),
		.rd_ready (log_ready),
		.rd_data  (fifo_out)
	);

	assign log_data = fifo_out[7:0];
	assign log_last = fifo_out[8];
	assign log_drop = fifo_out[9];
endmodule

// ### src/acl_regs.vh
// Constants for the access control entry action unit
// Behaviour
// - Mirror enabled: copy every matching frame
// - Mirror copies bypass the rate limiter
// - Mirror setting two-valued, disabled after reset
// - Log enabled: record matching frames, otherwise none
// - Log records omit the trailing check sequence
// - Log only frames shorter than limit, untagged
// - Shutdown enabled: disable the frame's ingress port
// - Shutdown only for frames shorter than limit
// - Readable hit counter, one per matching frame
// - Source filter any: source address ignored
// - Source filter specific: source must equal value
// - Source filter only for ethertype or ARP
// - Redirect matches to chosen port, rate limited; code redirects only entries with cfg_permit clear
// - Rate selection 1 to 16 units, else off
`ifndef ACL_REGS_VH
`define ACL_REGS_VH
`define ACL_MAX_LEN      12'h5ee
`define ACL_FCS_BYTES    3'h4
`define ACL_TAG_BYTES    12'h004
`define ACL_MAX_TAGS     2'h2
`define ACL_SMAC_FIRST   12'h006
`define ACL_SMAC_LAST    12'h00b
`define ACL_ETYPE_POS    12'h00c
`define ACL_TPID_C       16'h8100
`define ACL_TPID_S       16'h88a8
`define ACL_ETYPE_ARP    16'h0806
`define ACL_FT_ANY       2'h0
`define ACL_FT_ETYPE     2'h1
`define ACL_FT_ARP       2'h2
`define ACL_SRC_ANY      1'h0
`define ACL_SRC_SPECIFIC 1'h1
`define ACL_RATE_MIN     5'h01
`define ACL_RATE_MAX     5'h10
`define ACL_FIFO_DEPTH   16
`define ACL_POS_MAX      12'hfff
`endif

// ### src/acl_fifo.v
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/100ps
module acl_fifo #(
	parameter WIDTH = 10,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             ref_clk,
	input  wire             srst,
	input  wire             wr_valid,
	output wire             wr_ready,
	input  wire [WIDTH-1:0] wr_data,
	output wire             rd_valid,
	input  wire             rd_ready,
	output wire [WIDTH-1:0] rd_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wptr_reg;
	reg [AW-1:0]    rptr_reg;
	reg [AW:0]      cnt_reg;
	wire            full;
	wire            empty;
	wire            push;
	wire            pop;

	assign full     = (cnt_reg == DEPTH[AW:0]);
	assign empty    = (cnt_reg == {(AW+1){1'b0}});
	assign wr_ready = ~full;
	assign rd_valid = ~empty;
	assign push     = wr_valid & ~full;
	assign pop      = rd_ready & ~empty;
	assign rd_data  = mem[rptr_reg];

	always @(posedge ref_clk) begin
		if (push) begin
			mem[wptr_reg] <= wr_data;
		end
	end

	always @(posedge ref_clk) begin
		if (srst) begin
			wptr_reg <= {AW{1'b0}};
			rptr_reg <= {AW{1'b0}};
			cnt_reg  <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wptr_reg <= (wptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr_reg + 1'b1;
			end
			if (pop) begin
				rptr_reg <= (rptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr_reg + 1'b1;
			end
			if (push & ~pop) begin
				cnt_reg <= cnt_reg + 1'b1;
			end else if (pop & ~push) begin
				cnt_reg <= cnt_reg - 1'b1;
			end
		end
	end
endmodule

// ### src/acl_fcs_strip.v
// Byte delay line that drops the last four bytes of each frame
`timescale 1ns/100ps
`include "acl_regs.vh"
module acl_fcs_strip (
	input  wire       ref_clk,
	input  wire       srst,
	input  wire       in_valid,
	output wire       in_ready,
	input  wire [7:0] in_data,
	input  wire       in_last,
	input  wire       in_drop,
	output wire       out_valid,
	input  wire       out_ready,
	output wire [7:0] out_data,
	output wire       out_last,
	output wire       out_drop
);
	reg  [31:0] hold_reg;
	reg  [2:0]  fill_reg;
	wire        full;
	wire        take;

	// The byte leaving is four behind, so on the last input it is the last payload byte
	assign full      = (fill_reg == `ACL_FCS_BYTES);
	assign out_valid = in_valid & full;
	assign out_data  = hold_reg[31:24];
	assign out_last  = in_last;
	assign out_drop  = in_drop;
	assign in_ready  = out_ready | ~full;
	assign take      = in_valid & in_ready;

	always @(posedge ref_clk) begin
		if (srst) begin
			hold_reg <= 32'h0000_0000;
			fill_reg <= 3'h0;
		end else if (take) begin
			hold_reg <= {hold_reg[23:0], in_data};
			if (in_last) begin
				fill_reg <= 3'h0;
			end else if (!full) begin
				fill_reg <= fill_reg + 3'h1;
			end
		end
	end
endmodule

// ### tb/acl_entry_checker.sv
// Port-level checks for the access control entry unit
`timescale 1ns/100ps
module acl_entry_checker #(
	parameter NP = 8,
	parameter PW = 3,
	parameter CW = 32
) (
	input logic          ref_clk,
	input logic          srst,
	input logic          in_valid,
	input logic          in_ready,
	input logic          in_eof,
	input logic          cfg_permit,
	input logic          cfg_redirect_en,
	input logic          cfg_mirror_en,
	input logic [PW-1:0] cfg_mirror_port,
	input logic [4:0]    cfg_rate_sel,
	input logic          cfg_shutdown_en,
	input logic          cnt_clr,
	input logic          dec_valid,
	input logic          dec_mirror,
	input logic [PW-1:0] dec_mirror_port,
	input logic          dec_mirror_limit,
	input logic          dec_redirect,
	input logic          dec_rate_limit_en,
	input logic [4:0]    dec_rate_units,
	input logic [NP-1:0] port_disable,
	input logic [CW-1:0] hit_count,
	input logic          log_valid,
	input logic          log_ready,
	input logic [7:0]    log_data
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	property p_dec_after_eof; dec_valid |-> $past(in_valid && in_ready && in_eof); endproperty
	a_dec_after_eof: assert property (p_dec_after_eof) else $error("decision without last byte");
	property p_count; dec_valid && !$past(cnt_clr) |-> hit_count == $past(hit_count) + 1; endproperty
	a_count: assert property (p_count) else $error("hit count not stepped");
	property p_no_limit; dec_valid |-> !dec_mirror_limit; endproperty
	a_no_limit: assert property (p_no_limit) else $error("mirror copy rate limited");
	property p_redir; dec_valid && dec_redirect |-> $past(cfg_redirect_en && !cfg_permit); endproperty
	a_redir: assert property (p_redir) else $error("redirect on permit entry");
	property p_mirror;
		// The enable passes a register before the decision, hence two cycles back
		dec_valid |-> dec_mirror == $past(cfg_mirror_en, 2)
			&& (!dec_mirror || dec_mirror_port == $past(cfg_mirror_port));
	endproperty
	a_mirror: assert property (p_mirror) else $error("mirror decision wrong");
	property p_rate;
		dec_valid |-> dec_rate_limit_en == ($past(cfg_rate_sel) inside {[5'h01:5'h10]})
			&& dec_rate_units == (dec_rate_limit_en ? $past(cfg_rate_sel) : 5'h00);
	endproperty
	a_rate: assert property (p_rate) else $error("rate selection wrong");
	property p_shut; (port_disable & ~$past(port_disable)) != 0 |-> dec_valid && $past(cfg_shutdown_en); endproperty
	a_shut: assert property (p_shut) else $error("port disabled without cause");
	property p_log_hold; log_valid && !log_ready |=> log_valid && $stable(log_data); endproperty
	a_log_hold: assert property (p_log_hold) else $error("log byte lost before pop");
	property p_reset; $fell(srst) |-> hit_count == 0 && port_disable == 0 && !dec_mirror; endproperty
	a_reset: assert property (p_reset) else $error("state not cleared by reset");
	c_mirror: cover property (dec_valid && dec_mirror);
	c_shut: cover property (|port_disable);
	c_redir: cover property (dec_valid && dec_redirect);
endmodule
bind acl_entry acl_entry_checker #(.NP(NP), .PW(PW), .CW(CW)) i_chk (.ref_clk, .srst, .in_valid,
	.in_ready, .in_eof, .cfg_permit, .cfg_redirect_en, .cfg_mirror_en, .cfg_mirror_port,
	.cfg_rate_sel, .cfg_shutdown_en, .cnt_clr, .dec_valid, .dec_mirror, .dec_mirror_port,
	.dec_mirror_limit, .dec_redirect, .dec_rate_limit_en, .dec_rate_units, .port_disable,
	.hit_count, .log_valid, .log_ready, .log_data);

// ### tb/acl_src_model.sv
// Ingress port model sending frames byte by byte
`timescale 1ns/100ps
module acl_src_model (
	input  logic       ref_clk,
	input  logic       in_ready,
	output logic       in_valid,
	output logic [7:0] in_data,
	output logic       in_sof,
	output logic       in_eof,
	output logic [2:0] in_port
);
	int stalls = 0;
	initial begin
		in_valid = 1'b0;
		in_data = 8'h00;
		in_sof = 1'b0;
		in_eof = 1'b0;
		in_port = 3'h0;
	end
	task automatic send(input logic [2:0] port, input logic [47:0] src, input logic [15:0] et,
		input int len, input bit slow);
		logic [7:0] b;
		for (int i = 0; i < len; i++) begin
			b = i < 6 ? 8'h02 : i < 12 ? src[8*(11-i)+:8] : i == 12 ? et[15:8] :
				i == 13 ? et[7:0] : i[7:0];
			in_valid <= 1'b1;
			in_data <= b;
			in_sof <= (i == 0);
			in_eof <= (i == len - 1);
			in_port <= port;
			// Ready is settled between edges, so look at it on the falling edge
			@(negedge ref_clk);
			for (int k = 0; k < 500 && !in_ready; k++) @(negedge ref_clk);
			// A stuck ready abandons the frame so the bench cannot hang
			if (!in_ready) begin
				stalls++;
				return;
			end
			@(posedge ref_clk);
			if (slow) begin
				in_valid <= 1'b0;
				in_data <= ~b;
				@(posedge ref_clk);
			end
		end
	endtask
	task automatic idle();
		in_valid <= 1'b0;
		in_sof <= 1'b0;
		in_eof <= 1'b0;
		in_data <= ~in_data;
	endtask
endmodule

// ### tb/tb.sv
// Self-checking bench for the access control entry unit
`timescale 1ns/100ps
module tb;
	typedef struct {
		logic filt; logic [1:0] ftype; logic smatch; logic [15:0] et;
		int len; logic mir; logic shut; logic hit;
	} acl_row_t;
	acl_row_t rows [6] = '{'{0, 1, 0, 16'h0800, 64, 1, 0, 1}, '{1, 2, 1, 16'h0806, 60, 0, 1, 1},
		'{1, 1, 0, 16'h0800, 64, 1, 1, 0}, '{1, 0, 0, 16'h0800, 64, 1, 0, 1},
		'{0, 1, 0, 16'h0800, 1518, 1, 1, 1}, '{0, 1, 0, 16'h0800, 1517, 0, 1, 1}};
	logic [4:0] rates [5] = '{5'h03, 5'h00, 5'h01, 5'h10, 5'h11};
	logic ref_clk, srst, in_valid, in_ready, in_sof, in_eof, log_ready, log_valid, log_last;
	logic [7:0] in_data, log_data, port_disable, shutdown_clr, rec_byte;
	logic [2:0] in_port, dec_port, dec_mirror_port, dec_redirect_port;
	logic dec_valid, dec_mirror, dec_mirror_limit, dec_redirect, dec_rate_limit_en, log_drop;
	logic [4:0] dec_rate_units, cfg_rate_sel = 5'h00;
	logic [31:0] hit_count, hc;
	logic [47:0] sval = 48'h0a1b2c3d4e5f;
	logic cfg_permit = 0, cfg_src_filter = 0, cfg_mirror_en = 0, cfg_log_en = 1;
	logic cfg_shutdown_en = 0, cfg_redirect_en = 0, cnt_clr = 0, rec_drop = 0;
	logic [1:0] cfg_frame_type = 2'h1, cyc = 2'h0;
	int failures = 0, check_count = 0, dec_cnt = 0, rec_cnt = 0, rec_n = 0, rec_len = 0, d0, r0;
	acl_src_model i_src (.ref_clk, .in_ready, .in_valid, .in_data, .in_sof, .in_eof, .in_port);
	acl_entry i_dut (.ref_clk, .srst, .in_valid, .in_ready, .in_data, .in_sof, .in_eof, .in_port,
		.cfg_entry_en(1'b1), .cfg_port_mask(8'hff), .cfg_frame_type, .cfg_etype(16'h0800),
		.cfg_permit, .cfg_src_filter, .cfg_src_value(sval), .cfg_mirror_en,
		.cfg_mirror_port(3'h6), .cfg_log_en, .cfg_shutdown_en, .cfg_redirect_en,
		.cfg_redirect_port(3'h5), .cfg_rate_sel, .cnt_clr, .shutdown_clr, .dec_valid,
		.dec_port, .dec_mirror, .dec_mirror_port, .dec_mirror_limit, .dec_redirect,
		.dec_redirect_port, .dec_rate_limit_en, .dec_rate_units, .port_disable, .hit_count,
		.log_valid, .log_ready, .log_data, .log_last, .log_drop);
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	// Log sink stalls one cycle in four to exercise the FIFO back pressure
	always @(posedge ref_clk) begin
		cyc <= cyc + 2'h1;
		log_ready <= (cyc != 2'h3);
		if (dec_valid === 1'b1) dec_cnt <= dec_cnt + 1;
		if (log_valid === 1'b1 && log_ready) begin
			rec_n <= (log_last === 1'b1) ? 0 : rec_n + 1;
			if (log_last === 1'b1) begin
				rec_cnt <= rec_cnt + 1;
				rec_byte <= log_data;
				rec_len <= rec_n + 1;
				rec_drop <= log_drop;
			end
		end
	end
	task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s expected %0h seen %0h", nm, exp, got);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic frame(input logic [47:0] src, input logic [15:0] et, input int len, input bit slow);
		i_src.send(3'h3, src, et, len, slow);
		i_src.idle();
		repeat (3) @(posedge ref_clk);
	endtask
	task automatic wait_rec(input int n0);
		for (int k = 0; k < 400 && rec_cnt == n0; k++) @(posedge ref_clk);
		if (rec_cnt == n0) begin
			failures++;
			$display("unexpected log record missing");
			test_done();
		end
	endtask
	initial begin
		srst = 1'b1;
		shutdown_clr = 8'h00;
		repeat (12) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		chk("dec_mirror", 0, dec_mirror);
		foreach (rows[r]) begin
			hc = hit_count;
			d0 = dec_cnt;
			r0 = rec_cnt;
			cfg_src_filter <= rows[r].filt;
			cfg_frame_type <= rows[r].ftype;
			cfg_mirror_en <= rows[r].mir;
			cfg_shutdown_en <= rows[r].shut;
			shutdown_clr <= 8'hff;
			@(posedge ref_clk);
			shutdown_clr <= 8'h00;
			frame(rows[r].smatch ? sval : sval ^ 48'h1, rows[r].et, rows[r].len, r == 1);
			wait_rec(r0);
			chk("decision", rows[r].hit, dec_cnt - d0);
			chk("hit_count", hc + rows[r].hit, hit_count);
			if (rows[r].hit) chk("dec_mirror", rows[r].mir, dec_mirror);
			chk("port_disable", rows[r].hit & rows[r].shut & (rows[r].len < 1518), port_disable[3]);
			chk("log length", rows[r].len - 4, rec_len);
			chk("log last byte", (rows[r].len - 5) & 8'hff, rec_byte);
			chk("log drop", !(rows[r].hit && rows[r].len < 1518), rec_drop);
			$display("row %0d done", r);
		end
		srst <= 1'b1;
		@(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		chk("port_disable", 0, port_disable);
		chk("hit_count", 0, hit_count);
		chk("dec_mirror", 0, dec_mirror);
		$display("reset test done");
		cfg_redirect_en <= 1'b1;
		cfg_frame_type <= 2'h1;
		cfg_shutdown_en <= 1'b0;
		cfg_mirror_en <= 1'b1;
		for (int t = 0; t < 5; t++) begin
			cfg_permit <= (t == 0);
			cfg_rate_sel <= rates[t];
			frame(sval, 16'h0800, 60, 1'b0);
			chk("dec_mirror", 1, dec_mirror);
			chk("dec_redirect", t != 0, dec_redirect);
			if (t != 0) chk("dec_redirect_port", 3'h5, dec_redirect_port);
			chk("dec_rate_limit_en", rates[t] inside {[1:16]}, dec_rate_limit_en);
			chk("dec_rate_units", (rates[t] inside {[1:16]}) ? rates[t] : 5'h00, dec_rate_units);
			chk("dec_port", 3'h3, dec_port);
			chk("dec_mirror_port", 3'h6, dec_mirror_port);
			chk("dec_mirror_limit", 0, dec_mirror_limit);
		end
		$display("redirect test done");
		cfg_log_en <= 1'b0;
		repeat (60) @(posedge ref_clk);
		hc = hit_count;
		d0 = dec_cnt;
		r0 = rec_cnt;
		i_src.send(3'h3, sval, 16'h0800, 20, 1'b0);
		i_src.send(3'h3, sval, 16'h0800, 15, 1'b1);
		i_src.send(3'h3, sval, 16'h0800, 20, 1'b0);
		i_src.idle();
		repeat (20) @(posedge ref_clk);
		chk("burst decisions", 3, dec_cnt - d0);
		chk("hit_count", hc + 3, hit_count);
		chk("log records", r0, rec_cnt);
		cnt_clr <= 1'b1;
		@(posedge ref_clk);
		cnt_clr <= 1'b0;
		@(posedge ref_clk);
		chk("hit_count cleared", 0, hit_count);
		$display("burst test done");
		// One tag takes 1521 bytes under the limit, so the port must shut
		cfg_frame_type <= 2'h0;
		cfg_shutdown_en <= 1'b1;
		frame(sval, 16'h8100, 1521, 1'b0);
		chk("tagged port_disable", 1, port_disable[3]);
		chk("ingress stalls", 0, i_src.stalls);
		$display("tag test done");
		test_done();
	end
endmodule
